// *** core/asr_ms_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_ms_timer
  import asr_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  asr_in_if.tick_mp io
);

  typedef struct packed {
    logic [MS_CNT_W-1:0] cnt;
    logic tick;
  } asr_tmr_s;

  asr_tmr_s st_ff;
  asr_tmr_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= MS_CNT_W'(MS_CYCLES_P - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + MS_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign io.tick = st_ff.tick;

endmodule
`default_nettype wire

// *** core/asr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_sync
  import asr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [PIN_N-1:0] pins,
  asr_in_if.sync_mp io
);

  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] q;
  } asr_sync_s;

  asr_sync_s st_ff;
  asr_sync_s nxt_st;

  // A level is accepted only when stages two and three agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < PIN_N; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign io.at_sel = st_ff.q[0];
  assign io.rst_on = st_ff.q[1];
  assign io.run = st_ff.q[2];
  assign io.key_stop = st_ff.q[3];
  assign io.key_any = st_ff.q[4];

endmodule
`default_nettype wire

// *** core/asr_top.sv ***
// Functional notes
// - Select on: frequency from current input
// - Select off: frequency from voltage input
// - Select unassigned: sum both analog inputs
// - Reset input performs reset, cancels trip
// - Reset executes on full on-off pulse
// - Alarm output cleared within 30 ms
// - Reset on: output off, trip cleared
// - Run still active restarts motor after reset
// - Reset held 4 s at powerup: comm error
// - Comm error clears: reset off, key pressed
// - Stop key resets only during alarm
// - Power-on performs the same reset sequence
// - Reset terminal accepts normally-open sense only
// - Reset while running lets motor coast
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module asr_top
  import asr_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic analog_source_select,
  input wire logic trip_reset_input,
  input wire logic run_cmd,
  input wire logic stop_reset_key,
  input wire logic any_key,
  input wire logic trip_event,
  input wire logic [ADC_W-1:0] volt_analog_input,
  input wire logic [ADC_W-1:0] current_analog_input,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [FREQ_W-1:0] freq_cmd,
  output logic motor_enable,
  output logic motor_coast,
  output logic alarm_out,
  output logic powerup_reset,
  output logic comm_error,
  output logic irq
);

  asr_in_if io();

  asr_sync u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pins({any_key, stop_reset_key, run_cmd, trip_reset_input, analog_source_select}),
    .io(io.sync_mp)
  );

  asr_ms_timer #(
    .MS_CYCLES_P(MS_CYCLES_P)
  ) u_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .io(io.tick_mp)
  );

  typedef struct packed {
    asr_state_e state;
    logic [1:0] src;
    logic sel_assigned;
    logic [FREQ_W-1:0] setpoint;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [WIDTH_CNT_W-1:0] rst_ms;
    logic [WIDTH_CNT_W-1:0] pu_ms;
    logic pu_hold;
    logic trip;
    logic alarm;
    logic comm_err;
    logic por;
    logic motor_en;
    logic coast;
    logic irq;
    logic [FREQ_W-1:0] freq;
    logic [31:0] rdata;
  } asr_top_s;

  asr_top_s st_ff;
  asr_top_s nxt_st;
  logic [3:0] ev;
  logic [FREQ_W-1:0] analog_sel;
  logic [3:0] w1c;

  function automatic logic [WIDTH_CNT_W-1:0] sat_inc(input logic [WIDTH_CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + WIDTH_CNT_W'(1);
  endfunction

  function automatic logic [FREQ_W-1:0] widen(input logic [ADC_W-1:0] v);
    widen = {1'b0, v};
  endfunction

  // Select is looked at every cycle, so switching needs no stop
  always_comb begin
    if (!st_ff.sel_assigned) begin
      analog_sel = widen(volt_analog_input) + widen(current_analog_input);
    end else if (io.at_sel) begin
      analog_sel = widen(current_analog_input);
    end else begin
      analog_sel = widen(volt_analog_input);
    end
  end

  always_comb begin
    nxt_st = st_ff;
    ev = 4'h0;
    w1c = 4'h0;
    nxt_st.por = 1'b0;
    nxt_st.rdata = 32'h0000_0000;

    // Register writes; the reset terminal's sense bit is never stored
    if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        nxt_st.src = reg_wdata[CTRL_SRC_LSB +: 2];
        nxt_st.sel_assigned = reg_wdata[CTRL_SEL_ASSIGNED];
      end else if (reg_addr == REG_SETPOINT) begin
        nxt_st.setpoint = reg_wdata[FREQ_W-1:0];
      end else if (reg_addr == REG_IRQ_STAT) begin
        w1c = reg_wdata[3:0];
      end else if (reg_addr == REG_IRQ_MASK) begin
        nxt_st.irq_mask = reg_wdata[3:0];
      end
    end

    case (st_ff.state)
      ST_PWRUP: begin
        // Power-on runs the same reset as a terminal pulse
        nxt_st.por = 1'b1;
        nxt_st.trip = 1'b0;
        nxt_st.alarm = 1'b0;
        nxt_st.state = ST_NORMAL;
      end
      ST_NORMAL: begin
        if (io.rst_on) begin
          nxt_st.state = ST_HELD;
          nxt_st.rst_ms = '0;
        end else if (io.key_stop && st_ff.alarm) begin
          nxt_st.trip = 1'b0;
          nxt_st.alarm = 1'b0;
          nxt_st.por = 1'b1;
          ev[IRQ_RESET_DONE] = 1'b1;
        end
      end
      ST_HELD: begin
        if (io.tick) begin
          nxt_st.rst_ms = sat_inc(st_ff.rst_ms);
        end
        // Clearing at the minimum width keeps the alarm well inside its limit
        if (st_ff.rst_ms >= MIN_PULSE_CNT) begin
          nxt_st.trip = 1'b0;
          nxt_st.alarm = 1'b0;
        end
        if (!io.rst_on) begin
          nxt_st.state = ST_NORMAL;
          if (st_ff.rst_ms >= MIN_PULSE_CNT) begin
            nxt_st.por = 1'b1;
            ev[IRQ_RESET_DONE] = 1'b1;
          end else begin
            ev[IRQ_SHORT_PULSE] = 1'b1;
          end
        end
      end
      default: begin
        nxt_st.state = ST_PWRUP;
      end
    endcase

    // A fault arriving with a clear still wins; none is taken while reset is held
    if (trip_event && st_ff.state != ST_HELD) begin
      nxt_st.trip = 1'b1;
      nxt_st.alarm = 1'b1;
      ev[IRQ_TRIP] = 1'b1;
    end

    // Reset held continuously from power-up for too long
    // The synchroniser starts low, so the pin is judged only at a tick, once it has settled
    if (!io.rst_on) begin
      if (io.tick) begin
        nxt_st.pu_hold = 1'b0;
      end
    end else if (st_ff.pu_hold && io.tick) begin
      nxt_st.pu_ms = sat_inc(st_ff.pu_ms);
    end
    if (st_ff.pu_hold && io.rst_on && st_ff.pu_ms >= COMM_ERR_CNT && !st_ff.comm_err) begin
      nxt_st.comm_err = 1'b1;
      ev[IRQ_COMM_ERR] = 1'b1;
    end else if (!io.rst_on && io.key_any) begin
      nxt_st.comm_err = 1'b0;
    end

    // Output follows run at once after a reset; no fresh run edge is needed
    nxt_st.motor_en = io.run && !nxt_st.trip && nxt_st.state == ST_NORMAL && !nxt_st.por;
    nxt_st.coast = nxt_st.state == ST_HELD;

    if (st_ff.src == SRC_ANALOG) begin
      nxt_st.freq = analog_sel;
    end else begin
      nxt_st.freq = st_ff.setpoint;
    end

    nxt_st.irq_stat = (st_ff.irq_stat & ~w1c) | ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        nxt_st.rdata = {29'h0, st_ff.sel_assigned, st_ff.src};
      end else if (reg_addr == REG_SETPOINT) begin
        nxt_st.rdata = {19'h0, st_ff.setpoint};
      end else if (reg_addr == REG_STATUS) begin
        nxt_st.rdata = {22'h0, st_ff.state, io.run, io.rst_on, io.at_sel,
                        st_ff.comm_err, st_ff.motor_en, st_ff.alarm, st_ff.trip};
      end else if (reg_addr == REG_IRQ_STAT) begin
        nxt_st.rdata = {28'h0, st_ff.irq_stat};
      end else if (reg_addr == REG_IRQ_MASK) begin
        nxt_st.rdata = {28'h0, st_ff.irq_mask};
      end else if (reg_addr == REG_FREQ) begin
        nxt_st.rdata = {19'h0, st_ff.freq};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.state <= ST_PWRUP;
      st_ff.src <= CTRL_SRC_RST;
      st_ff.sel_assigned <= CTRL_ASSIGNED_RST;
      st_ff.setpoint <= SETPOINT_RST;
      st_ff.irq_mask <= IRQ_MASK_RST;
      st_ff.pu_hold <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign freq_cmd = st_ff.freq;
  assign motor_enable = st_ff.motor_en;
  assign motor_coast = st_ff.coast;
  assign alarm_out = st_ff.alarm;
  assign powerup_reset = st_ff.por;
  assign comm_error = st_ff.comm_err;
  assign irq = st_ff.irq;

endmodule
`default_nettype wire

// *** include/asr_in_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface asr_in_if;
  logic at_sel;
  logic rst_on;
  logic run;
  logic key_stop;
  logic key_any;
  logic tick;
  modport sync_mp(output at_sel, output rst_on, output run, output key_stop, output key_any);
  modport tick_mp(output tick);
  modport core_mp(input at_sel, input rst_on, input run, input key_stop, input key_any, input tick);
endinterface
`default_nettype wire

// *** include/asr_pkg.sv ***
package asr_pkg;

  // Clock and timing
  localparam int CLK_HZ = 125000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int MS_CNT_W = 17;
  localparam int MIN_PULSE_MS = 12;
  localparam int ALARM_CLR_MS = 30;
  localparam int COMM_ERR_S = 4;
  localparam int COMM_ERR_MS = COMM_ERR_S * MS_PER_S;
  localparam int WIDTH_CNT_W = 13;
  localparam logic [WIDTH_CNT_W-1:0] MIN_PULSE_CNT = WIDTH_CNT_W'(MIN_PULSE_MS);
  localparam logic [WIDTH_CNT_W-1:0] COMM_ERR_CNT = WIDTH_CNT_W'(COMM_ERR_MS);

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SETPOINT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_FREQ = 8'h14;

  // Control field positions and reset values
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_SEL_ASSIGNED = 2;
  localparam int CTRL_RST_NC = 3;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] CTRL_SRC_RST = 2'h0;
  localparam logic CTRL_ASSIGNED_RST = 1'b1;
  localparam logic [12:0] SETPOINT_RST = 13'h0000;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // Interrupt status bits
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_RESET_DONE = 1;
  localparam int IRQ_SHORT_PULSE = 2;
  localparam int IRQ_COMM_ERR = 3;

  localparam int ADC_W = 12;
  localparam int FREQ_W = 13;
  localparam int PIN_N = 5;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'b001,
    ST_NORMAL = 3'b010,
    ST_HELD = 3'b100
  } asr_state_e;

endpackage

// *** testbench/asr_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_chk
  import asr_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic trip_reset_input,
  input wire logic motor_enable,
  input wire logic motor_coast,
  input wire logic alarm_out,
  input wire logic powerup_reset,
  input wire logic comm_error
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Raw pin width; the design sees it a few cycles late, so limits keep a tick of slack
  int hi_cnt;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= trip_reset_input ? hi_cnt + 1 : 0;
    end
  end
  sequence long_rel;
    $fell(trip_reset_input) && hi_cnt > 14 * MS_CYCLES_P;
  endsequence
  sequence short_rel;
    $fell(trip_reset_input) && hi_cnt < 11 * MS_CYCLES_P;
  endsequence
  coast_no_drive_a: assert property (motor_coast |-> !motor_enable)
    else $error("drive on while coasting");
  hold_coast_a: assert property (trip_reset_input [*8] |=> motor_coast)
    else $error("no coast while reset held");
  release_run_a: assert property (!trip_reset_input [*8] |=> !motor_coast)
    else $error("coast after reset released");
  alarm_clear_a: assert property (hi_cnt >= 30 * MS_CYCLES_P |-> !alarm_out)
    else $error("alarm not cleared in time");
  pulse_one_a: assert property (powerup_reset |=> !powerup_reset)
    else $error("power-up reset longer than one cycle");
  long_reset_a: assert property (long_rel |-> ##[1:8] powerup_reset)
    else $error("full pulse gave no reset");
  short_ignored_a: assert property (short_rel |-> !powerup_reset [*8])
    else $error("short pulse gave a reset");
  comm_err_a: assert property ($rose(comm_error) |-> hi_cnt >= 3999 * MS_CYCLES_P)
    else $error("comm error too early");
endmodule
bind asr_top asr_chk #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .trip_reset_input(trip_reset_input), .motor_enable(motor_enable), .motor_coast(motor_coast),
  .alarm_out(alarm_out), .powerup_reset(powerup_reset), .comm_error(comm_error));
`default_nettype wire

// *** testbench/asr_plc.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_plc (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic hold,
  input wire logic [15:0] width,
  output logic reset_pin
);
  logic [15:0] left_ff = 16'h0;
  always_ff @(posedge ref_clk) begin
    if (go) begin
      left_ff <= width;
    end else if (left_ff != 16'h0) begin
      left_ff <= left_ff - 16'h1;
    end
  end
  // Contact is normally open: low unless a pulse or a hold closes it
  assign reset_pin = hold || (left_ff != 16'h0);
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
  import asr_pkg::*;
;
  localparam int P = 10;
  logic ref_clk = 1'b0, nrst = 1'b0, sel = 1'b0, run = 1'b0, skey = 1'b0, akey = 1'b0, trip = 1'b0;
  logic wr = 1'b0, rd = 1'b0, go = 1'b0, hold = 1'b0, pin, men, coast, alarm, pr, cerr, irq, seen;
  logic [11:0] volt = 12'h123, cur = 12'h456;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [15:0] width = 16'h0;
  logic [FREQ_W-1:0] freq;
  int n_errors = 0, checks_done = 0;
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  asr_plc plc (.ref_clk(ref_clk), .go(go), .hold(hold), .width(width), .reset_pin(pin));
  asr_top #(.MS_CYCLES_P(P)) uut (.ref_clk(ref_clk), .nrst(nrst), .analog_source_select(sel),
    .trip_reset_input(pin), .run_cmd(run), .stop_reset_key(skey), .any_key(akey), .trip_event(trip),
    .volt_analog_input(volt), .current_analog_input(cur), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .freq_cmd(freq), .motor_enable(men),
    .motor_coast(coast), .alarm_out(alarm), .powerup_reset(pr), .comm_error(cerr), .irq(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are registered, so values read at an edge are those of the cycle before it
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      if (pr === 1'b1) seen = 1'b1;
    end
  endtask
  task wrr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask
  task pulse(input logic [15:0] w);
    @(posedge ref_clk);
    go <= 1'b1;
    width <= w;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask
  task fault;
    trip <= 1'b1;
    cyc(1);
    trip <= 1'b0;
    cyc(3);
  endtask
  task do_reset;
    nrst <= 1'b0;
    cyc(8);
    nrst <= 1'b1;
    watch(6);
    chk(seen, 1'b1);
  endtask
  task t_regs;
    rdr(REG_CTRL);
    chk(d, 32'h4);
    wrr(REG_CTRL, 32'hc);
    rdr(REG_CTRL);
    chk(d, 32'h4);
    rdr(REG_IRQ_MASK);
    chk(d, 32'h0);
    rdr(8'hfc);
    chk(d, 32'h0);
    $display("regs done");
  endtask
  task t_freq;
    wrr(REG_CTRL, 32'h5);
    cyc(8);
    chk(freq, 13'h0123);
    sel <= 1'b1;
    cyc(8);
    chk(freq, 13'h0456);
    wrr(REG_CTRL, 32'h1);
    cyc(3);
    chk(freq, 13'h0579);
    wrr(REG_SETPOINT, 32'habc);
    wrr(REG_CTRL, 32'h4);
    cyc(3);
    chk(freq, 13'h0abc);
    sel <= 1'b0;
    $display("freq done");
  endtask
  task t_trip;
    run <= 1'b1;
    wrr(REG_IRQ_MASK, 32'h3);
    cyc(8);
    fault;
    chk({alarm, men, irq}, 3'b101);
    pulse(16'd320);
    cyc(8);
    chk({coast, men}, 2'b10);
    cyc(130);
    chk({coast, alarm}, 2'b10);
    fault;
    chk(alarm, 1'b0);
    watch(200);
    chk(seen, 1'b1);
    cyc(3);
    chk(men, 1'b1);
    rdr(REG_IRQ_STAT);
    chk(d[1:0], 2'b11);
    wrr(REG_IRQ_STAT, 32'h3);
    rdr(REG_IRQ_STAT);
    chk({d[1:0], irq}, 3'b000);
    run <= 1'b0;
    $display("trip reset done");
  endtask
  task t_short;
    pulse(16'd60);
    watch(80);
    chk(seen, 1'b0);
    rdr(REG_IRQ_STAT);
    chk(d[2], 1'b1);
    $display("short pulse done");
  endtask
  task t_key;
    skey <= 1'b1;
    watch(10);
    chk(seen, 1'b0);
    skey <= 1'b0;
    // Let the released key leave the synchroniser, or the fault is cleared at once
    cyc(6);
    fault;
    skey <= 1'b1;
    watch(10);
    skey <= 1'b0;
    chk({seen, alarm}, 2'b10);
    $display("key done");
  endtask
  task t_comm;
    hold <= 1'b1;
    do_reset;
    cyc(40100);
    chk(cerr, 1'b1);
    hold <= 1'b0;
    cyc(8);
    chk(cerr, 1'b1);
    akey <= 1'b1;
    cyc(8);
    akey <= 1'b0;
    chk(cerr, 1'b0);
    $display("comm done");
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    do_reset;
    t_regs;
    t_freq;
    t_trip;
    t_short;
    t_key;
    t_comm;
    finish_test;
  end
  initial begin
    cyc(50000);
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
